//--- rtl/mfin_divider.sv
// signed restoring divider used for the characteristic slope
// assumes start is a pulse; operands taken at start
`timescale 1ns/1ns
module mfin_divider #(
  parameter int W = 34
) (
  input  wire logic                core_clk,
  input  wire logic                reset,
  input  wire logic                clk_en,
  input  wire logic                start,
  input  wire logic signed [W-1:0] dividend,
  input  wire logic signed [W-1:0] divisor,
  output logic                     busy,
  output logic                     done,
  output logic signed [W-1:0]      quotient
);
  logic [W-1:0]        rem;
  logic [W-1:0]        quo;
  logic [W-1:0]        dvs;
  logic                neg;
  logic [$clog2(W):0]  cnt;
  wire  [W:0]          trial  = {rem, quo[W-1]};
  wire  [W:0]          diff   = trial - {1'b0, dvs};
  wire                 fits   = ~diff[W];
  wire  [W-1:0]        a_abs  = dividend[W-1] ? -dividend : dividend;
  wire  [W-1:0]        b_abs  = divisor[W-1] ? -divisor : divisor;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      rem <= '0;
      quo <= '0;
      dvs <= '0;
      neg <= 1'b0;
      cnt <= '0;
      busy <= 1'b0;
      done <= 1'b0;
      quotient <= '0;
    end
    else if (clk_en)
    begin
      done <= 1'b0;
      if (start)
      begin
        rem <= '0;
        quo <= a_abs;
        dvs <= (b_abs == '0) ? W'(1) : b_abs;
        neg <= dividend[W-1] ^ divisor[W-1];
        cnt <= ($clog2(W)+1)'(W);
        busy <= 1'b1;
      end
      else if (busy)
      begin
        rem <= fits ? diff[W-1:0] : trial[W-1:0];
        quo <= {quo[W-2:0], fits};
        cnt <= cnt - 1'b1;
        if (cnt == ($clog2(W)+1)'(1))
        begin
          busy <= 1'b0;
          done <= 1'b1;
          quotient <= neg ? -$signed({quo[W-2:0], fits}) : $signed({quo[W-2:0], fits});
        end
      end
    end
  end
endmodule

//--- rtl/mfin_filter.sv
// first-order averaging low-pass, one step per sample tick
// assumes tick period set by tick_ns; coefficient is tick over time constant
`timescale 1ns/1ns
`include "mfin_params.svh"
module mfin_filter #(
  parameter int TICK_NS = `MFIN_TICK_NS
) (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               clk_en,
  input  wire logic               step,
  input  wire logic [3:0]         tc_sel,
  input  wire logic signed [16:0] din,
  output logic signed [16:0]      dout
);
  // accumulator keeps 16 fraction bits so small steps are not lost
  logic signed [32:0] acc;

  function automatic logic [15:0] tc_ms(input logic [3:0] s);
    case (s)
      4'h0: tc_ms = 16'h0000;
      4'h1: tc_ms = 16'h0002;
      4'h2: tc_ms = 16'h0004;
      4'h3: tc_ms = 16'h0008;
      4'h4: tc_ms = 16'h0010;
      4'h5: tc_ms = 16'h0020;
      4'h6: tc_ms = 16'h0040;
      4'h7: tc_ms = 16'h0080;
      4'h8: tc_ms = 16'h0100;
      4'h9: tc_ms = 16'h0200;
      4'ha: tc_ms = 16'h03e8;
      4'hb: tc_ms = 16'h07d0;
      4'hc: tc_ms = 16'h0bb8;
      4'hd: tc_ms = 16'h0fa0;
      default: tc_ms = 16'h1388;
    endcase
  endfunction

  wire  [15:0]        tc     = tc_ms(tc_sel);                    // [RULE17]
  wire  [31:0]        ticks  = 32'(tc) * 32'(1000000 / TICK_NS);
  wire  signed [33:0] err    = 34'(din) * 34'sh10000 - 34'(acc);
  wire  signed [33:0] delta  = (ticks <= 32'h1) ? err : err / $signed({2'b0, ticks});
  wire  signed [33:0] next_a = 34'(acc) + delta;

  assign dout = (tc == 16'h0) ? din : 17'(acc >>> 16);         // [RULE17]

  always_ff @(posedge core_clk)
  begin
    if (reset)
      acc <= '0;                                                // [RULE22]
    else if (clk_en && step)
      acc <= next_a[32:0];                                      // [RULE18]
  end
endmodule

//--- rtl/mfin_params.svh
// constants for the multifunction input scaling block
// assumes percent values in hundredths (0.01 %), frequencies in 0.01 Hz
// Summary of operation
// RULE1: mode code selects unipolar, current, digital, bipolar or one of three thermistors.
// RULE2: outputs of modes not selected are driven to zero; the overcurrent fault stays set after leaving current mode until cleared.
// RULE3: digital path samples slowly; use it only for non time-critical signals.
// RULE4: after reset the mode is the 0 to 10 V voltage input.
// RULE5: in current mode a sample above maximum raises the overcurrent fault.
// RULE6: two points per each of four data sets; defaults 2/0 and 98/100 percent.
// RULE7: X is percent of full scale input, Y percent of max limit.
// RULE8: output is Y = (Y2-Y1)/(X2-X1)*(X-X1)+Y1.
// RULE9: sign of mapped output selects direction of rotation.
// RULE10: frequency output clamped to min and max, 0 to 599 Hz, max 50 Hz default.
// RULE11: min frequency default 3.50 Hz for classes 1xx/4xx, else 0 Hz.
// RULE12: bipolar output uses the limit magnitudes symmetrically for both directions.
// RULE13: percent output clamped to min/max 0 to 300 %, defaults 0 and 100 %.
// RULE14: effective upper frequency limit is max frequency plus compensated slip.
// RULE15: tolerance band around zero 0 to 25 % of full scale, default 2 %.
// RULE16: with nonzero minimum, output holds the signed minimum until input crosses the band.
// RULE17: filter time constant from 15 values, 0 to 5000 ms; 0 bypasses.
// RULE18: nonzero setting averages the reference with that time constant.
// RULE19: configurer should check point one input when low-signal monitoring is on.
// RULE20: low-signal monitor modes: off, warn, warn plus stop, warn plus fault and coast.
// RULE21: mapping, limits, hysteresis and filter update once per sample tick.
// RULE22: after reset filter and hysteresis state start at zero.
`ifndef MFIN_PARAMS_SVH
`define MFIN_PARAMS_SVH
`define MFIN_MODE_VOLT      4'h1
`define MFIN_MODE_CURR      4'h2
`define MFIN_MODE_DIG       4'h3
`define MFIN_MODE_BIP       4'h4
`define MFIN_MODE_PTC       4'hb
`define MFIN_MODE_KTY       4'hc
`define MFIN_MODE_PT        4'hd
`define MFIN_FULL_PCT       17'sh02710
`define MFIN_X1_DEF         16'h00c8
`define MFIN_Y1_DEF         16'h0000
`define MFIN_X2_DEF         16'h2648
`define MFIN_Y2_DEF         16'h2710
`define MFIN_FMAX_LIM       16'he9fc
`define MFIN_FMAX_DEF       16'h1388
`define MFIN_FMIN_DEF_A     16'h015e
`define MFIN_FMIN_DEF_B     16'h0000
`define MFIN_PMAX_LIM       16'h7530
`define MFIN_PMAX_DEF       16'h2710
`define MFIN_PMIN_DEF       16'h0000
`define MFIN_TOL_LIM        16'h09c4
`define MFIN_TOL_DEF        16'h00c8
`define MFIN_LOW_VOLT       16'h03e8
`define MFIN_LOW_CURR       16'h03e8
`define MFIN_TC_DEF         4'h0
`define MFIN_TICK_NS        1000000
`endif

//--- rtl/mfin_pkg.sv
// types for the multifunction input scaling block
// assumes mfin_params.svh for numeric constants
package mfin_pkg;
  typedef logic [3:0] mfin_mode_t;
  typedef enum logic [2:0]
  {
    mfin_idle_s = 3'b001,
    mfin_div_s  = 3'b010,
    mfin_out_s  = 3'b100
  } mfin_state_t;
  typedef logic signed [16:0] mfin_val_t;
endpackage

//--- rtl/mfin_scale.sv
// multifunction input: mode select, two-point map, limits, hysteresis, filter
// assumes sample and tick synchronous to core_clk; sample in 0.01 % of full scale
`timescale 1ns/1ns
`include "mfin_params.svh"
module mfin_scale #(
  parameter int TICK_NS = `MFIN_TICK_NS
) (
  input  wire logic                   core_clk,
  input  wire logic                   reset,
  input  wire logic                   clk_en,
  input  wire logic                   sample_tick,
  input  wire logic signed [16:0]     sample_pct,
  input  wire logic                   digital_level,
  input  wire logic                   thermistor_hot,
  input  wire logic                   class_zero_min,
  input  wire logic                   percent_cfg,
  input  wire logic                   reverse_dir,
  input  wire logic [15:0]            slip_comp,
  input  wire logic [1:0]             low_mon_mode,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [11:0]            paddr,
  input  wire logic [31:0]            pwdata,
  output logic [31:0]                 prdata,
  output logic                        pready,
  output logic                        pslverr,
  output logic signed [16:0]          ref_out,
  output logic                        ref_valid,
  output logic                        dir_reverse,
  output logic                        mfin_digital_path,
  output logic                        thermistor_trip,
  output logic                        input_overcurrent_fault,
  output logic                        low_warn,
  output logic                        low_stop,
  output logic                        low_fault
);
  import mfin_pkg::*;

  localparam logic [11:0] A_MODE = 12'h000;
  localparam logic [11:0] A_SET  = 12'h004;
  localparam logic [11:0] A_PT1  = 12'h008;
  localparam logic [11:0] A_PT2  = 12'h00c;
  localparam logic [11:0] A_FLIM = 12'h010;
  localparam logic [11:0] A_PLIM = 12'h014;
  localparam logic [11:0] A_TOL  = 12'h018;
  localparam logic [11:0] A_STAT = 12'h01c;
  localparam logic [11:0] A_OUT  = 12'h020;

  mfin_mode_t   mode;
  logic [1:0]   set_sel;
  logic [3:0]   tc_sel;
  logic [15:0]  px1 [4];
  logic [15:0]  py1 [4];
  logic [15:0]  px2 [4];
  logic [15:0]  py2 [4];
  logic [15:0]  fmin;
  logic [15:0]  fmax;
  logic [15:0]  pmin;
  logic [15:0]  pmax;
  logic [15:0]  tol;
  logic         ovc_flag;
  logic         hold_pos;
  logic         hold_neg;
  logic         fmin_loaded;
  mfin_state_t  state;
  logic signed [16:0] x_lat;
  logic signed [16:0] mapped;

  // apb decode; every access completes in its first access cycle
  wire acc_w    = psel & penable & pwrite;
  wire acc_r    = psel & penable & ~pwrite;
  wire mapped_a = (paddr <= A_OUT) && (paddr[1:0] == 2'b00);
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~mapped_a;

  wire is_analog = (mode == `MFIN_MODE_VOLT) || (mode == `MFIN_MODE_CURR) ||
                   (mode == `MFIN_MODE_BIP);                               // [RULE1]
  wire is_therm  = (mode == `MFIN_MODE_PTC) || (mode == `MFIN_MODE_KTY) ||
                   (mode == `MFIN_MODE_PT);
  wire legal_mode = is_analog || is_therm || (mode == `MFIN_MODE_DIG);

  // characteristic numerator and denominator for the divider
  wire signed [33:0] dy   = 34'($signed(py2[set_sel])) - 34'($signed(py1[set_sel]));
  // divider starts on the tick edge, before x_lat holds the new sample
  wire signed [16:0] x_cur = (state == mfin_idle_s) ? sample_pct : x_lat;
  wire signed [33:0] dxin = 34'(x_cur) - 34'($signed({1'b0, px1[set_sel]}));
  wire signed [33:0] dx   = 34'($signed({1'b0, px2[set_sel]})) -
                            34'($signed({1'b0, px1[set_sel]}));
  wire signed [33:0] quot;
  wire               div_done;
  wire               div_start = (state == mfin_idle_s) && sample_tick && is_analog;

  mfin_divider #(.W(34)) u_div (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .start    (div_start),
    .dividend (dy * dxin),                                                 // [RULE8]
    .divisor  (dx),
    .busy     (),
    .done     (div_done),
    .quotient (quot)
  );

  // y in 0.01 % of the active upper limit
  wire signed [33:0] y_pct   = quot + 34'($signed(py1[set_sel]));            // [RULE8]
  wire [16:0]        up_lim  = percent_cfg ? {1'b0, pmax} :
                               17'(fmax) + 17'(slip_comp);                   // [RULE14]
  wire [15:0]        lo_lim  = percent_cfg ? pmin : fmin;                    // [RULE13]
  wire signed [50:0] scaled  = 51'(y_pct) * 51'($signed({1'b0, up_lim})) /
                               51'(`MFIN_FULL_PCT);                          // [RULE7]
  wire               neg_y   = scaled[50];
  wire [50:0]        mag_y   = neg_y ? -scaled : scaled;
  wire [16:0]        mag_cl  = (mag_y > 51'(up_lim)) ? up_lim :
                               (mag_y < 51'(lo_lim)) ? 17'(lo_lim) : mag_y[16:0];// [RULE10] [RULE12]

  // hysteresis: zero region widened by the tolerance band
  wire signed [16:0] tol_s   = $signed({1'b0, tol});
  wire               in_band = ($signed(dxin[16:0]) > -tol_s) &&
                               ($signed(dxin[16:0]) < tol_s);                 // [RULE15]
  wire               below_n = $signed(dxin[16:0]) <= -tol_s;
  wire               above_p = $signed(dxin[16:0]) >= tol_s;
  wire               hys_on  = (lo_lim != 16'h0);
  wire               keep_p  = hold_pos & ~below_n;
  wire               keep_n  = hold_neg & ~above_p;
  wire               next_hp = hys_on & (keep_p | (~neg_y & ~in_band & ~keep_n));
  wire               next_hn = hys_on & (keep_n | (neg_y & ~in_band & ~keep_p));
  wire signed [16:0] next_map =
      (hys_on && hold_pos && !below_n && (in_band || neg_y)) ? $signed({1'b0, lo_lim}) :
      (hys_on && hold_neg && !above_p && (in_band || !neg_y)) ? -$signed({1'b0, lo_lim}) :
      (!hys_on && in_band) ? 17'sh0 :
      neg_y ? -$signed(mag_cl) : $signed(mag_cl);                               // [RULE16] [RULE9]

  wire signed [16:0] filt_out;
  mfin_filter #(.TICK_NS(TICK_NS)) u_filt (
    .core_clk (core_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .step     (state == mfin_out_s),                                       // [RULE21]
    .tc_sel   (tc_sel),
    .din      (mapped),
    .dout     (filt_out)
  );

  // low-signal threshold: 1 V or 2 mA, both 10 % of full scale
  wire low_sig = (mode == `MFIN_MODE_CURR) ? (sample_pct < $signed({1'b0, `MFIN_LOW_CURR})) :
                 (sample_pct < $signed({1'b0, `MFIN_LOW_VOLT}));
  wire mon_act = is_analog && (mode != `MFIN_MODE_BIP) && (low_mon_mode != 2'h0);

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state <= mfin_idle_s;
      x_lat <= '0;
      mapped <= '0;                                                        // [RULE22]
      hold_pos <= 1'b0;
      hold_neg <= 1'b0;
      ref_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_valid <= 1'b0;
      unique case (state)
        mfin_idle_s:
        begin
          if (div_start)
          begin
            x_lat <= sample_pct;
            state <= mfin_div_s;
          end
        end
        mfin_div_s:
        begin
          if (div_done)
          begin
            mapped <= next_map;
            hold_pos <= next_hp;
            hold_neg <= next_hn;
            state <= mfin_out_s;
          end
        end
        mfin_out_s:
        begin
          ref_valid <= 1'b1;
          state <= mfin_idle_s;
        end
        default: state <= mfin_idle_s;
      endcase
    end
  end

  // outputs of modes not selected are held at zero
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      ref_out <= '0;
      dir_reverse <= 1'b0;
      mfin_digital_path <= 1'b0;
      thermistor_trip <= 1'b0;
      low_warn <= 1'b0;
      low_stop <= 1'b0;
      low_fault <= 1'b0;
    end
    else if (clk_en)
    begin
      ref_out <= is_analog ? filt_out : 17'sh0;                             // [RULE2]
      dir_reverse <= is_analog & (filt_out[16] ^ reverse_dir);               // [RULE9]
      mfin_digital_path <= (mode == `MFIN_MODE_DIG) & digital_level;         // [RULE2] [RULE3]
      thermistor_trip <= is_therm & thermistor_hot;                         // [RULE2]
      low_warn <= mon_act & low_sig;                                        // [RULE20]
      low_stop <= mon_act & low_sig & (low_mon_mode == 2'h2);               // [RULE20]
      low_fault <= mon_act & low_sig & (low_mon_mode == 2'h3);              // [RULE20]
    end
  end

  wire [31:0] stat_word = {26'h0, hold_neg, hold_pos, ~legal_mode, low_warn,
                           mfin_digital_path, ovc_flag};
  assign input_overcurrent_fault = ovc_flag;

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      mode <= `MFIN_MODE_VOLT;                                              // [RULE4]
      set_sel <= 2'h0;
      tc_sel <= `MFIN_TC_DEF;
      for (int i = 0; i < 4; i++)
      begin
        px1[i] <= `MFIN_X1_DEF;                                             // [RULE6]
        py1[i] <= `MFIN_Y1_DEF;
        px2[i] <= `MFIN_X2_DEF;
        py2[i] <= `MFIN_Y2_DEF;
      end
      fmin <= `MFIN_FMIN_DEF_A;
      fmax <= `MFIN_FMAX_DEF;
      pmin <= `MFIN_PMIN_DEF;
      pmax <= `MFIN_PMAX_DEF;
      tol <= `MFIN_TOL_DEF;
      ovc_flag <= 1'b0;
      fmin_loaded <= 1'b0;
      prdata <= '0;
    end
    else if (clk_en)
    begin
      // class strap caught one cycle after reset release
      if (!fmin_loaded)
      begin
        fmin_loaded <= 1'b1;
        fmin <= class_zero_min ? `MFIN_FMIN_DEF_B : `MFIN_FMIN_DEF_A;      // [RULE11]
      end
      // set wins over a software clear in the same cycle
      if (mode == `MFIN_MODE_CURR && sample_tick && sample_pct > `MFIN_FULL_PCT)
        ovc_flag <= 1'b1;                                                   // [RULE5]
      else if (acc_w && paddr == A_STAT && pwdata[0])
        ovc_flag <= 1'b0;
      if (acc_w)
      begin
        unique case (paddr)
          A_MODE: mode <= pwdata[3:0];
          A_SET:
          begin
            set_sel <= pwdata[1:0];
            tc_sel <= (pwdata[11:8] > 4'he) ? 4'he : pwdata[11:8];
          end
          A_PT1:
          begin
            px1[set_sel] <= (pwdata[15:0] > 16'(`MFIN_FULL_PCT)) ? 16'(`MFIN_FULL_PCT) : pwdata[15:0];
            py1[set_sel] <= pwdata[31:16];
          end
          A_PT2:
          begin
            px2[set_sel] <= (pwdata[15:0] > 16'(`MFIN_FULL_PCT)) ? 16'(`MFIN_FULL_PCT) : pwdata[15:0];
            py2[set_sel] <= pwdata[31:16];
          end
          A_FLIM:
          begin
            fmin <= (pwdata[15:0] > `MFIN_FMAX_LIM) ? `MFIN_FMAX_LIM : pwdata[15:0];
            fmax <= (pwdata[31:16] > `MFIN_FMAX_LIM) ? `MFIN_FMAX_LIM : pwdata[31:16];
          end
          A_PLIM:
          begin
            pmin <= (pwdata[15:0] > `MFIN_PMAX_LIM) ? `MFIN_PMAX_LIM : pwdata[15:0];
            pmax <= (pwdata[31:16] > `MFIN_PMAX_LIM) ? `MFIN_PMAX_LIM : pwdata[31:16];
          end
          A_TOL: tol <= (pwdata[15:0] > `MFIN_TOL_LIM) ? `MFIN_TOL_LIM : pwdata[15:0];
          default: ;
        endcase
      end
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          A_MODE:  prdata <= {28'h0, mode};
          A_SET:   prdata <= {20'h0, tc_sel, 6'h0, set_sel};
          A_PT1:   prdata <= {py1[set_sel], px1[set_sel]};
          A_PT2:   prdata <= {py2[set_sel], px2[set_sel]};
          A_FLIM:  prdata <= {fmax, fmin};
          A_PLIM:  prdata <= {pmax, pmin};
          A_TOL:   prdata <= {16'h0, tol};
          A_STAT:  prdata <= stat_word;
          A_OUT:   prdata <= {{15{ref_out[16]}}, ref_out};
          default: prdata <= '0;
        endcase
      end
    end
  end
endmodule

//--- tb/mfin_scale_chk.sv
// checker for mfin_scale: bus answer, sample timing, mode-gated outputs
// assumes it is bound into mfin_scale and sees only its ports
`timescale 1ns/1ns
module mfin_scale_chk (
  input wire logic               core_clk,
  input wire logic               reset,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               sample_tick,
  input wire logic               ref_valid,
  input wire logic signed [16:0] ref_out,
  input wire logic               mfin_digital_path,
  input wire logic               thermistor_trip,
  input wire logic               input_overcurrent_fault,
  input wire logic               low_warn,
  input wire logic               low_stop,
  input wire logic               low_fault
);
  logic [3:0] mode_q;
  logic [3:0] mode_d;
  wire        acc     = psel && penable;
  wire        clr     = acc && pwrite && paddr == 12'h01c && pwdata[0];
  wire        therm_q = mode_q inside {4'hb, 4'hc, 4'hd};
  wire        therm_d = mode_d inside {4'hb, 4'hc, 4'hd};
  // shadow of the mode register, so mode gating can be judged from the pins
  always_ff @(posedge core_clk)
  begin
    if (reset)
      mode_q <= 4'h1;
    else if (acc && pwrite && paddr == 12'h000)
      mode_q <= pwdata[3:0];
    mode_d <= mode_q;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  sequence s_answer;
    $past(sample_tick, 37) ##1 !ref_valid;
  endsequence
  chk_pready_high: assert property (pready) else $error("pready low");
  chk_unmapped_err: assert property (acc && paddr > 12'h020 |-> pslverr)
    else $error("no error on unmapped access");
  chk_mapped_ok: assert property (acc && paddr <= 12'h020 && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped access");
  chk_valid_latency: assert property (ref_valid |-> s_answer)
    else $error("ref_valid not tied to tick");
  chk_ref_hold: assert property ($changed(ref_out) && !$past(acc && pwrite, 2) |->
    ref_valid || $past(ref_valid))
    else $error("ref_out moved outside update");
  chk_dig_gated: assert property (mode_q != 4'h3 && mode_d != 4'h3 |-> !mfin_digital_path)
    else $error("digital path high outside digital mode");
  chk_therm_gated: assert property (!therm_q && !therm_d |-> !thermistor_trip)
    else $error("thermistor trip outside thermistor mode");
  chk_fault_sticky: assert property (input_overcurrent_fault && !clr |=> input_overcurrent_fault)
    else $error("overcurrent fault dropped without clear");
  chk_low_warn: assert property (low_stop || low_fault |-> low_warn)
    else $error("stop or fault without warning");
endmodule

bind mfin_scale mfin_scale_chk i_chk (.*);

//--- tb/mfin_src.sv
// analog sample source feeding mfin_scale
// assumes go is a one-cycle request from the bench, driven after a rising edge
`timescale 1ns/1ns
module mfin_src (
  input wire logic          core_clk,
  input wire logic          go,
  input wire logic signed [16:0] value,
  output logic              sample_tick,
  output logic signed [16:0] sample_pct
);
  initial
  begin
    sample_tick = 1'b0;
    sample_pct = 17'sh00000;
  end
  // ticks only on request: slow, non time-critical sampling
  always @(posedge core_clk)
  begin
    sample_tick <= go;
    sample_pct <= go ? value : ~sample_pct;
  end
endmodule

//--- tb/tb_multifunction_input_scaling.sv
// self-checking bench for mfin_scale over APB and the sample source
// assumes a 50 MHz core_clk and clk_en and class strap held constant
`timescale 1ns/1ns
module tb_multifunction_input_scaling;
  logic core_clk = 0, reset = 1, clk_en = 1, class_zero_min = 0, go = 0;
  logic digital_level = 0, thermistor_hot = 0, percent_cfg = 0, reverse_dir = 0;
  logic psel = 0, penable = 0, pwrite = 0, rerr;
  logic [15:0] slip_comp = 0;
  logic [1:0]  low_mon_mode = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rdat;
  logic signed [16:0] src_val = 0;
  wire sample_tick, pready, pslverr, ref_valid, dir_reverse, mfin_digital_path;
  wire thermistor_trip, input_overcurrent_fault, low_warn, low_stop, low_fault;
  wire signed [16:0] sample_pct, ref_out;
  wire [31:0] prdata;
  int failures = 0, n_checks = 0;
  always #10 core_clk = ~core_clk;
  mfin_src i_src (.core_clk, .go, .value(src_val), .sample_tick, .sample_pct);
  mfin_scale i_dut (.*);
  task report_and_stop;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    for (int i = 0; i < 20 && pready !== 1'b1; i++) @(posedge core_clk);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ref_out settles with the ref_valid pulse, or the cycle after it when the filter is on
  task run(input int v);
    src_val <= 17'(v);
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    for (int i = 0; i < 100 && ref_valid !== 1'b1; i++) @(posedge core_clk);
    @(posedge core_clk);
  endtask
  task samp(input int v, input int e, input string nm);
    run(v);
    chk(nm, ref_out, e);
  endtask
  task t_regs;
    logic [11:0] a [8] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018, 12'h024};
    logic [31:0] e [8] = '{32'h1, 32'h0, 32'hc8, 32'h27102648, 32'h1388015e, 32'h27100000,
                           32'hc8, 32'h0};
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk("reset reg", rdat, e[i]);
      chk("slverr", rerr, i == 7);
    end
    apb(1'b1, 12'h024, 32'hffff);
    apb(1'b0, 12'h024, 32'h0);
    chk("unmapped read", rdat, 32'h0);
    $display("test regs done");
  endtask
  task t_map;
    apb(1'b1, 12'h008, 32'h0);
    apb(1'b1, 12'h00c, 32'h27102710);
    samp(4000, 2000, "map mid");
    samp(100, 350, "map fmin");
    chk("dir fwd", dir_reverse, 1'b0);
    apb(1'b1, 12'h004, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk("set2 point", rdat, 32'hc8);
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b0, 12'h008, 32'h0);
    chk("set0 point", rdat, 32'h0);
    $display("test map done");
  endtask
  task t_limit;
    apb(1'b1, 12'h00c, 32'h27101388);
    apb(1'b1, 12'h010, 32'h03e8015e);
    slip_comp <= 16'h0064;
    samp(8000, 1100, "fmax slip");
    apb(1'b1, 12'h010, 32'h1388015e);
    apb(1'b1, 12'h00c, 32'h27102710);
    slip_comp <= 16'h0000;
    $display("test limit done");
  endtask
  task t_hyst;
    apb(1'b1, 12'h000, 32'h4);
    samp(-100, 350, "hold pos");
    samp(-4000, -2000, "bipolar neg");
    chk("dir rev", dir_reverse, 1'b1);
    samp(100, -350, "hold neg");
    samp(4000, 2000, "bipolar pos");
    chk("dir fwd", dir_reverse, 1'b0);
    reverse_dir <= 1'b1;
    run(4000);
    chk("dir input", dir_reverse, 1'b1);
    reverse_dir <= 1'b0;
    $display("test hyst done");
  endtask
  task t_pct;
    apb(1'b1, 12'h000, 32'h1);
    percent_cfg <= 1'b1;
    samp(4000, 4000, "percent");
    percent_cfg <= 1'b0;
    for (int m = 1; m < 4; m++)
    begin
      low_mon_mode <= 2'(m);
      run(500);
      chk("low warn", low_warn, 1'b1);
      chk("low stop", low_stop, m == 2);
      chk("low fault", low_fault, m == 3);
    end
    low_mon_mode <= 2'h0;
    run(5000);
    chk("low off", low_warn, 1'b0);
    $display("test pct done");
  endtask
  task t_cur;
    apb(1'b1, 12'h000, 32'h2);
    run(10000);
    chk("ocf edge", input_overcurrent_fault, 1'b0);
    run(10001);
    chk("ocf set", input_overcurrent_fault, 1'b1);
    apb(1'b0, 12'h01c, 32'h0);
    chk("ocf status", rdat[0], 1'b1);
    apb(1'b1, 12'h01c, 32'h1);
    wt(2);
    chk("ocf clear", input_overcurrent_fault, 1'b0);
    $display("test cur done");
  endtask
  task t_dig;
    logic [3:0] tm [3] = '{4'hb, 4'hc, 4'hd};
    apb(1'b1, 12'h000, 32'h3);
    digital_level <= 1'b1;
    wt(3);
    chk("digital", mfin_digital_path, 1'b1);
    thermistor_hot <= 1'b1;
    for (int i = 0; i < 3; i++)
    begin
      apb(1'b1, 12'h000, 32'(tm[i]));
      wt(3);
      chk("trip", thermistor_trip, 1'b1);
      chk("dig off", mfin_digital_path, 1'b0);
    end
    apb(1'b1, 12'h000, 32'h1);
    wt(3);
    chk("trip off", thermistor_trip, 1'b0);
    thermistor_hot <= 1'b0;
    digital_level <= 1'b0;
    $display("test dig done");
  endtask
  task t_filt;
    int lo, hi, tgt, prev;
    samp(4000, 2000, "bypass");
    prev = 2000;
    for (int c = 1; c < 15; c++)
    begin
      tgt = c[0] ? 4000 : 2000;
      lo = prev < tgt ? prev : tgt;
      hi = prev < tgt ? tgt : prev;
      apb(1'b1, 12'h004, 32'(c) << 8);
      run(c[0] ? 8000 : 4000);
      chk("filter", ref_out >= lo && ref_out <= hi && ref_out != tgt, 1'b1);
      prev = ref_out;
    end
    $display("test filt done");
  endtask
  initial
  begin
    repeat (20000) @(posedge core_clk);
    failures++;
    report_and_stop;
  end
  initial
  begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_regs;
    t_map;
    t_limit;
    t_hyst;
    t_pct;
    t_cur;
    t_dig;
    t_filt;
    report_and_stop;
  end
endmodule
